// *** rtl/nvs_pkg.sv ***
/*
  Shared constants, states and carriers of the serial nonvolatile memory target.
  Assumes one 20 MHz system clock; the bus clock is sampled, never used as a clock.
*/
`default_nettype none
package nvs_pkg;
  localparam int          ADDR_W     = 15;
  localparam int          MEM_DEPTH  = 32768;
  localparam int          FIFO_DEPTH = 16;
  localparam logic [3:0]  BIT_ACK    = 4'h8;
  localparam logic [3:0]  BIT_ZERO   = 4'h0;
  localparam logic [3:0]  BIT_ONE    = 4'h1;
  localparam logic [14:0] ADDR_ZERO  = 15'h0000;
  localparam logic [14:0] ADDR_ONE   = 15'h0001;
  localparam logic [14:0] ADDR_MAX   = 15'h7FFF;
  localparam logic [1:0]  ID_LAST    = 2'h2;
  localparam logic [1:0]  ID_ZERO    = 2'h0;
  localparam logic [1:0]  ID_ONE     = 2'h1;
  // Type codes are arbitrary values
  localparam logic [3:0]  DEV_TYPE   = 4'hC;
  localparam logic [3:0]  ID_TYPE    = 4'hE;
  localparam logic [3:0]  SLEEP_TYPE = 4'hD;
  // Identity values are arbitrary
  localparam logic [7:0]  ID_MAKER   = 8'h5A;
  localparam logic [7:0]  ID_DENSITY = 8'h22;
  localparam logic [7:0]  ID_REV     = 8'h01;

  typedef enum logic [2:0] {
    NVS_IDLE    = 3'b000,
    NVS_DEVADDR = 3'b001,
    NVS_ADDR_HI = 3'b010,
    NVS_ADDR_LO = 3'b011,
    NVS_WDATA   = 3'b100,
    NVS_RDATA   = 3'b101,
    NVS_IGNORE  = 3'b110
  } nvs_state_t;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
  } nvs_wr_t;

  typedef struct packed {
    logic [7:0] maker;
    logic [7:0] density;
    logic [7:0] revision;
  } nvs_id_t;
endpackage

`default_nettype wire

// *** rtl/nvs_i2c_slave.sv ***
/*
  Write buffer and two-wire bus target with its byte array.
  Assumes scl/sda/strap/protect pins are asynchronous and the master drives the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module nvs_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW:0]      wr_ptr_reg;
  logic [PW:0]      rd_ptr_reg;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;
  wire              full = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                           (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);

  assign in_ready  = ~full;
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data  = store[rd_ptr_reg[PW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr_reg[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (PW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (PW+1)'(pop);
    end
  end
endmodule

// Operation
// - Byte array of 32,768 eight-bit locations reached over the serial bus.
// - Each received data byte is committed at once, no busy period.
// - Respond only when address select bits equal the three strap pins.
// - Unconnected strap pins count as zero through internal pull-downs.
// - Sample data on clock rising edges, change output on falling edges.
// - Write-protect high blocks every array change; low allows all writes.
// - Data line is only pulled low or released, never driven high.
// - Read-only identity record gives maker, density and revision.
// - Sleep starts once the sleep request is received, stop optional.
// - First byte holds type code, three select bits, then direction bit.
// - Write sends two address bytes; 15 bits kept, top bit ignored.
// - Address advances after every byte, wraps to zero, bursts unlimited.
// - Read continues on master acknowledge, ends on master non-acknowledge.
module nvs_i2c_slave #(
  parameter int MEM_DEPTH  = nvs_pkg::MEM_DEPTH,
  parameter int FIFO_DEPTH = nvs_pkg::FIFO_DEPTH
) (
  input  wire logic           clk,
  input  wire logic           reset,
  input  wire logic           scl_in,
  input  wire logic           sda_in,
  output logic                sda_out,
  output logic                sda_oe,
  input  wire logic [2:0]     device_select_straps,
  input  wire logic           write_protect,
  output logic                sleep_active,
  output nvs_pkg::nvs_id_t    identity_record
);
  logic [7:0]          mem [0:MEM_DEPTH-1];
  logic [1:0]          scl_sync_reg;
  logic [1:0]          sda_sync_reg;
  logic [2:0]          strap_sync1_reg;
  logic [2:0]          strap_sync2_reg;
  logic [1:0]          wp_sync_reg;
  logic                scl_prev_reg;
  logic                sda_prev_reg;
  nvs_pkg::nvs_state_t state_reg;
  logic [3:0]          bit_cnt_reg;
  logic                ack_phase_reg;
  logic                mnack_reg;
  logic [7:0]          shift_reg;
  logic [7:0]          tx_reg;
  logic [14:0]         addr_reg;
  logic                id_mode_reg;
  logic [1:0]          id_idx_reg;
  logic                sleep_reg;
  logic                oe_reg;
  logic [7:0]          rd_data_reg;
  nvs_pkg::nvs_wr_t    wr_in;
  nvs_pkg::nvs_wr_t    wr_out;
  logic                fifo_in_ready;
  logic                fifo_out_valid;

  wire scl_s     = scl_sync_reg[1];
  wire sda_s     = sda_sync_reg[1];
  wire wp_s      = wp_sync_reg[1];
  wire scl_rise  = scl_s & ~scl_prev_reg;
  wire scl_fall  = ~scl_s & scl_prev_reg;
  wire start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  wire active    = (state_reg != nvs_pkg::NVS_IDLE) && (state_reg != nvs_pkg::NVS_IGNORE);
  wire byte_done = scl_fall & ~ack_phase_reg & (bit_cnt_reg == nvs_pkg::BIT_ACK) & active;
  wire ack_end   = scl_fall & ack_phase_reg;
  wire bit_fall  = scl_fall & ~ack_phase_reg & (bit_cnt_reg != nvs_pkg::BIT_ZERO) &
                   (bit_cnt_reg != nvs_pkg::BIT_ACK) & (state_reg == nvs_pkg::NVS_RDATA);
  // Device byte fields: type code, select bits, direction
  wire sel_hit   = shift_reg[3:1] == strap_sync2_reg;
  wire dev_hit   = (shift_reg[7:4] == nvs_pkg::DEV_TYPE) & sel_hit;
  wire id_hit    = (shift_reg[7:4] == nvs_pkg::ID_TYPE) & sel_hit & shift_reg[0];
  wire sleep_hit = (shift_reg[7:4] == nvs_pkg::SLEEP_TYPE) & sel_hit & ~shift_reg[0];
  wire in_wdata  = state_reg == nvs_pkg::NVS_WDATA;
  wire in_rdata  = state_reg == nvs_pkg::NVS_RDATA;
  wire tx_load   = ack_end & in_rdata & ~mnack_reg;
  wire fifo_push = byte_done & in_wdata & ~wp_s & fifo_in_ready;
  wire wdata_ack = fifo_in_ready | wp_s;
  wire mem_we    = fifo_out_valid & ~tx_load;
  wire [14:0] addr_inc = (addr_reg == nvs_pkg::ADDR_MAX) ? nvs_pkg::ADDR_ZERO :
                         addr_reg + nvs_pkg::ADDR_ONE;
  wire [7:0]  id_byte  = (id_idx_reg == nvs_pkg::ID_ZERO) ? identity_record.maker :
                         (id_idx_reg == nvs_pkg::ID_ONE)  ? identity_record.density :
                                                            identity_record.revision;
  wire [7:0]  tx_byte  = id_mode_reg ? id_byte : rd_data_reg;

  assign identity_record = '{maker: nvs_pkg::ID_MAKER, density: nvs_pkg::ID_DENSITY,
                             revision: nvs_pkg::ID_REV};
  assign sda_out      = 1'b0;
  assign sda_oe       = oe_reg;
  assign sleep_active = sleep_reg;
  assign wr_in        = '{addr: addr_reg, data: shift_reg};

  nvs_fifo #(
    .WIDTH ($bits(nvs_pkg::nvs_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_in),
    .out_valid (fifo_out_valid),
    .out_ready (~tx_load),
    .out_data  (wr_out)
  );

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[wr_out.addr[$clog2(MEM_DEPTH)-1:0]] <= wr_out.data;
    end
    rd_data_reg <= mem[addr_reg[$clog2(MEM_DEPTH)-1:0]];
  end

  // pins synchronised, pull-downs hold unconnected straps low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_sync_reg    <= 2'h3;
      sda_sync_reg    <= 2'h3;
      scl_prev_reg    <= 1'b1;
      sda_prev_reg    <= 1'b1;
      strap_sync1_reg <= 3'h0;
      strap_sync2_reg <= 3'h0;
      wp_sync_reg     <= 2'h0;
    end else begin
      scl_sync_reg    <= {scl_sync_reg[0], scl_in};
      sda_sync_reg    <= {sda_sync_reg[0], sda_in};
      scl_prev_reg    <= scl_sync_reg[1];
      sda_prev_reg    <= sda_sync_reg[1];
      strap_sync1_reg <= device_select_straps;
      strap_sync2_reg <= strap_sync1_reg;
      wp_sync_reg     <= {wp_sync_reg[0], write_protect};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg     <= nvs_pkg::NVS_IDLE;
      bit_cnt_reg   <= nvs_pkg::BIT_ZERO;
      ack_phase_reg <= 1'b0;
      mnack_reg     <= 1'b0;
      shift_reg     <= 8'h00;
      tx_reg        <= 8'hFF;
      addr_reg      <= nvs_pkg::ADDR_ZERO;
      id_mode_reg   <= 1'b0;
      id_idx_reg    <= nvs_pkg::ID_ZERO;
      sleep_reg     <= 1'b0;
      oe_reg        <= 1'b0;
    end else if (start_det) begin
      state_reg     <= nvs_pkg::NVS_DEVADDR;
      bit_cnt_reg   <= nvs_pkg::BIT_ZERO;
      ack_phase_reg <= 1'b0;
      sleep_reg     <= 1'b0;
      oe_reg        <= 1'b0;
    end else if (stop_det) begin
      state_reg     <= nvs_pkg::NVS_IDLE;
      ack_phase_reg <= 1'b0;
      oe_reg        <= 1'b0;
    end else if (scl_rise && active) begin
      if (ack_phase_reg) begin
        mnack_reg <= sda_s;
      end else begin
        shift_reg   <= {shift_reg[6:0], sda_s};
        bit_cnt_reg <= bit_cnt_reg + nvs_pkg::BIT_ONE;
      end
    end else if (byte_done) begin
      ack_phase_reg <= 1'b1;
      mnack_reg     <= 1'b0;
      case (state_reg)
        nvs_pkg::NVS_DEVADDR: begin
          oe_reg      <= dev_hit | id_hit | sleep_hit;
          id_mode_reg <= id_hit;
          id_idx_reg  <= nvs_pkg::ID_ZERO;
          sleep_reg   <= sleep_hit;
          if (dev_hit) begin
            state_reg <= shift_reg[0] ? nvs_pkg::NVS_RDATA : nvs_pkg::NVS_ADDR_HI;
          end else if (id_hit) begin
            state_reg <= nvs_pkg::NVS_RDATA;
          end else begin
            state_reg <= nvs_pkg::NVS_IGNORE;
          end
        end
        nvs_pkg::NVS_ADDR_HI: begin
          addr_reg[14:8] <= shift_reg[6:0];
          oe_reg         <= 1'b1;
          state_reg      <= nvs_pkg::NVS_ADDR_LO;
        end
        nvs_pkg::NVS_ADDR_LO: begin
          addr_reg[7:0] <= shift_reg;
          oe_reg        <= 1'b1;
          state_reg     <= nvs_pkg::NVS_WDATA;
        end
        nvs_pkg::NVS_WDATA: begin
          oe_reg <= wdata_ack;
          if (wdata_ack) begin
            addr_reg <= addr_inc;
          end else begin
            state_reg <= nvs_pkg::NVS_IGNORE;
          end
        end
        nvs_pkg::NVS_RDATA: begin
          oe_reg <= 1'b0;
          if (id_mode_reg) begin
            id_idx_reg <= (id_idx_reg == nvs_pkg::ID_LAST) ? nvs_pkg::ID_ZERO :
                          id_idx_reg + nvs_pkg::ID_ONE;
          end else begin
            addr_reg <= addr_inc;
          end
        end
        default: begin
          oe_reg <= 1'b0;
        end
      endcase
    end else if (ack_end) begin
      ack_phase_reg <= 1'b0;
      bit_cnt_reg   <= nvs_pkg::BIT_ZERO;
      // continue on ack, stop on nack
      if (tx_load) begin
        tx_reg <= {tx_byte[6:0], 1'b1};
        oe_reg <= ~tx_byte[7];
      end else begin
        oe_reg <= 1'b0;
        if (in_rdata) begin
          state_reg <= nvs_pkg::NVS_IGNORE;
        end
      end
    end else if (bit_fall) begin
      tx_reg <= {tx_reg[6:0], 1'b1};
      oe_reg <= ~tx_reg[7];
    end
  end

  a_sda_low_only: assert property (@(posedge clk) disable iff (reset) !sda_out)
    else $error("sda driven high");
  a_wp_blocks_push: assert property (@(posedge clk) disable iff (reset)
    fifo_push |-> !wp_s) else $error("write pushed while protected");
  a_commit_prompt: assert property (@(posedge clk) disable iff (reset)
    fifo_push |=> ##[0:2] mem_we) else $error("byte not committed promptly");
  a_sda_on_fall: assert property (@(posedge clk) disable iff (reset)
    $changed(oe_reg) |-> $past(scl_fall | start_det | stop_det)) else $error("sda moved off fall");
  a_select_miss: assert property (@(posedge clk) disable iff (reset)
    byte_done && state_reg == nvs_pkg::NVS_DEVADDR && !sel_hit |=> state_reg == nvs_pkg::NVS_IGNORE
    && !oe_reg) else $error("responded to foreign select");
  a_dir_decode: assert property (@(posedge clk) disable iff (reset)
    byte_done && state_reg == nvs_pkg::NVS_DEVADDR && dev_hit |=> state_reg ==
    ($past(shift_reg[0]) ? nvs_pkg::NVS_RDATA : nvs_pkg::NVS_ADDR_HI)) else $error("bad direction");
  a_addr_wrap: assert property (@(posedge clk) disable iff (reset)
    byte_done && in_rdata && !id_mode_reg && addr_reg == nvs_pkg::ADDR_MAX |=>
    addr_reg == nvs_pkg::ADDR_ZERO) else $error("address did not wrap");
  a_addr_hi_latch: assert property (@(posedge clk) disable iff (reset)
    byte_done && state_reg == nvs_pkg::NVS_ADDR_HI |=> addr_reg[14:8] == $past(shift_reg[6:0]))
    else $error("high address not latched");
  a_read_nack_end: assert property (@(posedge clk) disable iff (reset)
    ack_end && in_rdata && mnack_reg |=> state_reg == nvs_pkg::NVS_IGNORE && !oe_reg)
    else $error("read did not end on nack");
  a_sleep_entry: assert property (@(posedge clk) disable iff (reset)
    byte_done && state_reg == nvs_pkg::NVS_DEVADDR && sleep_hit |=> sleep_active)
    else $error("sleep not entered");
  a_wp_ack_skip: assert property (@(posedge clk) disable iff (reset)
    byte_done && in_wdata && wp_s |-> !fifo_push ##1 (oe_reg && addr_reg == $past(addr_inc)))
    else $error("protected byte not acked");

  c_write_byte: cover property (@(posedge clk) disable iff (reset) fifo_push);
  c_read_byte: cover property (@(posedge clk) disable iff (reset) tx_load);
  c_sleep: cover property (@(posedge clk) disable iff (reset) $rose(sleep_reg));
  c_read_nack: cover property (@(posedge clk) disable iff (reset) ack_end && in_rdata && mnack_reg);
endmodule

`default_nettype wire

// *** tb/nvs_master_model.sv ***
/*
  Behavioural two-wire bus master: makes the bus clock and pulls the data wire low.
  Assumes the bench resolves the data wire with a pull-up and calls one task at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module nvs_master_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // Bus clock stands high between frames
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start();
    tick(2);
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask

  // Data moves only while the clock is low
  task automatic put_bit(input logic b);
    tick(2);
    sda_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    tick(2);
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(2);
    b = sda;
    tick(2);
    scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask

  // acknowledge asks for more, withheld ends the read
  task automatic rbyte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(~ack);
  endtask
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
/*
  Self-checking bench of the serial memory target: random bursts, wrap, protect, identity, sleep.
  Assumes the master model owns the bus clock; inputs move on the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic               clk;
  logic               reset;
  logic               scl;
  logic               m_low;
  wire                sda;
  logic               sda_oe;
  logic               sda_out;
  logic               wp;
  logic               sleep_active;
  logic [2:0]         straps;
  nvs_pkg::nvs_id_t   id_rec;
  int                 fail_count;
  int                 n_compared;
  logic [31:0]        seed;
  logic [7:0]         shadow [logic [14:0]];

  assign sda = ~(m_low | (sda_oe & ~sda_out));

  nvs_i2c_slave u_dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .device_select_straps(straps), .write_protect(wp),
    .sleep_active(sleep_active), .identity_record(id_rec));

  nvs_master_model u_master (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] rnd();
    for (int i = 0; i < 8; i++) begin
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    end
    return seed[7:0];
  endfunction

  task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_bit(input string name, input logic e, input logic g);
    check_byte(name, {7'h00, e}, {7'h00, g});
  endtask

  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic set_addr(input logic [2:0] sel, input logic [14:0] a);
    logic       ack;
    logic [7:0] hi;
    hi = rnd();
    u_master.start();
    u_master.wbyte({nvs_pkg::DEV_TYPE, sel, 1'b0}, ack);
    check_bit("device ack", 1'b1, ack);
    u_master.wbyte({hi[7], a[14:8]}, ack);
    check_bit("addr hi ack", 1'b1, ack);
    u_master.wbyte(a[7:0], ack);
    check_bit("addr lo ack", 1'b1, ack);
  endtask

  task automatic write_burst(input logic [2:0] sel, input logic [14:0] a, input int n);
    logic       ack;
    logic [7:0] d;
    set_addr(sel, a);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      u_master.wbyte(d, ack);
      check_bit("data ack", 1'b1, ack);
      if (!wp) begin
        shadow[a + 15'(i)] = d;
      end
    end
  endtask

  // Repeated start straight after a write: no busy period allowed
  task automatic read_burst(input logic [2:0] sel, input logic [14:0] a, input int n);
    logic       ack;
    logic [7:0] d;
    // Reads use the current address, so load it by a write header first
    set_addr(sel, a);
    u_master.start();
    u_master.wbyte({nvs_pkg::DEV_TYPE, sel, 1'b1}, ack);
    check_bit("read ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      u_master.rbyte(i != n - 1, d);
      check_byte("read data", shadow[a + 15'(i)], d);
      check_bit("sda out", 1'b0, sda_out);
    end
    check_bit("sda released", 1'b0, sda_oe);
    u_master.stop();
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial begin
    logic        ack;
    logic [7:0]  d;
    logic [2:0]  sel;
    logic [14:0] a;
    reset      = 1'b1;
    wp         = 1'b0;
    straps     = 3'h0;
    seed       = 32'h000176FA;
    fail_count = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check_bit("oe after reset", 1'b0, sda_oe);
    check_bit("sleep after reset", 1'b0, sleep_active);
    write_burst(3'h0, 15'h0010, 3);
    read_burst(3'h0, 15'h0010, 3);
    for (int k = 0; k < 3; k++) begin
      d = rnd();
      sel = d[2:0];
      straps = sel;
      a = {d[6:0], rnd()};
      write_burst(sel, a, 2 + (d[7] ? 3 : 0));
      read_burst(sel, a, 2 + (d[7] ? 3 : 0));
      u_master.start();
      u_master.wbyte({nvs_pkg::DEV_TYPE, sel ^ (3'h1 << k), 1'b0}, ack);
      check_bit("other select", 1'b0, ack);
      u_master.wbyte({~nvs_pkg::DEV_TYPE, sel, 1'b0}, ack);
      u_master.start();
      u_master.wbyte({~nvs_pkg::DEV_TYPE, sel, 1'b0}, ack);
      check_bit("other type", 1'b0, ack);
      u_master.stop();
    end
    write_burst(sel, nvs_pkg::ADDR_MAX, 2);
    read_burst(sel, nvs_pkg::ADDR_MAX, 2);
    wp = 1'b1;
    write_burst(sel, 15'h0010, 2);
    u_master.start();
    u_master.wbyte({nvs_pkg::DEV_TYPE, sel, 1'b1}, ack);
    u_master.rbyte(1'b0, d);
    check_byte("after protect", shadow[15'h0012], d);
    u_master.stop();
    read_burst(sel, 15'h0010, 2);
    wp = 1'b0;
    u_master.start();
    u_master.wbyte({nvs_pkg::ID_TYPE, sel, 1'b1}, ack);
    check_bit("identity ack", 1'b1, ack);
    u_master.rbyte(1'b1, d);
    check_byte("maker", nvs_pkg::ID_MAKER, d);
    u_master.rbyte(1'b1, d);
    check_byte("density", nvs_pkg::ID_DENSITY, d);
    u_master.rbyte(1'b0, d);
    check_byte("revision", nvs_pkg::ID_REV, d);
    u_master.stop();
    check_byte("identity port", nvs_pkg::ID_MAKER, id_rec.maker);
    check_byte("identity density", nvs_pkg::ID_DENSITY, id_rec.density);
    check_byte("identity revision", nvs_pkg::ID_REV, id_rec.revision);
    u_master.start();
    u_master.wbyte({nvs_pkg::SLEEP_TYPE, sel, 1'b0}, ack);
    check_bit("sleep ack", 1'b1, ack);
    for (int w = 0; w < 16 && sleep_active !== 1'b1; w++) begin
      @(negedge clk);
    end
    check_bit("sleep without stop", 1'b1, sleep_active);
    stop_test();
  end
endmodule

`default_nettype wire
